// ### rtl/sers_status_unit.sv
// Purpose: Latched event registers, masks, status byte and error queue
// Assumes: Command parser delivers one-cycle query and set strobes on CLK
// Notes: Nonvolatile storage lives outside; its values arrive as ports
// Overview of operation
// - Clear-status zeroes all events, empties queue
// - Event bits latch until register cleared
// - Event register query returns value, then clears
// - Reset zeroes all event registers
// - Standard summary bit 5 from masked events
// - Comm error summary at bit 2
// - Instrument summary at bit 0
// - Lock summary at bit 1
// - Bit 4 shows output buffer not empty
// - Master summary bit 6 drives service request
// - Status byte read changes nothing
// - Masks change only on explicit write or the power-up load
// - Power-on clear flag decides standard and request mask retention
// - Queue of 20, oldest first, overflow code
// - Empty queue reads as code zero
// - Standard event bit layout fixed
`timescale 1ns/1ns
module sers_status_unit
    import sers_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    // Event pulses from the instrument, same clock
    input wire logic STD_OPC_EV,
    input wire logic STD_QUERY_ERR_EV,
    input wire logic STD_DEV_ERR_EV,
    input wire logic STD_EXEC_ERR_EV,
    input wire logic STD_CMD_ERR_EV,
    input wire logic STD_PWR_ON_EV,
    input wire logic [7:0] COMM_ERROR_EV,
    input wire logic [7:0] INSTR_EV,
    input wire logic [7:0] LOCK_EV,
    input wire logic OUT_BUF_NOT_EMPTY,
    // Error code push
    input wire logic ERR_PUSH,
    input wire logic [7:0] ERR_CODE,
    // Commands
    input wire logic CLEAR_STATUS,
    input wire logic EV_QUERY,
    input wire logic [2:0] EV_SEL,
    input wire logic MASK_WRITE,
    input wire logic [7:0] MASK_WDATA,
    input wire logic AUX_QUERY,
    input wire logic AUX_WRITE,
    input wire logic [1:0] AUX_SEL,
    // Nonvolatile image, valid at power-up
    input wire logic NV_PWR_CLEAR,
    input wire logic [7:0] NV_SRQ_MASK,
    input wire logic [7:0] NV_STD_MASK,
    output logic [7:0] QUERY_DATA,
    output logic QUERY_VALID,
    output logic [7:0] STATUS_BYTE,
    output logic SERVICE_REQUEST,
    output logic PWR_CLEAR_FLAG,
    output logic [7:0] SRQ_MASK_OUT,
    output logic [7:0] STD_MASK_OUT
);
    // ****************************************
    // Reset synchroniser
    // ****************************************
    logic rst_meta_reg;
    logic rst_sync_n;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end
    function automatic logic any_masked(input logic [7:0] ev, input logic [7:0] mask);
        any_masked = |(ev & mask);
    endfunction
    // ****************************************
    // Event registers and masks
    // ****************************************
    logic [7:0] std_ev_reg, std_ev_next, comm_ev_reg, comm_ev_next;
    logic [7:0] instr_ev_reg, instr_ev_next, lock_ev_reg, lock_ev_next;
    logic [7:0] std_mask_reg, std_mask_next, comm_mask_reg, comm_mask_next;
    logic [7:0] instr_mask_reg, instr_mask_next, lock_mask_reg, lock_mask_next;
    logic [7:0] srq_mask_reg, srq_mask_next;
    logic pwr_clear_reg, pwr_clear_next;
    logic load_done_reg, load_done_next;
    logic [7:0] std_set, status_byte;
    logic ev_query_rd;
    // Error queue storage
    logic [7:0] queue_mem [QUEUE_DEPTH];
    logic [QUEUE_PTR_W-1:0] rd_ptr_reg, rd_ptr_next, wr_ptr_reg, wr_ptr_next;
    logic [QUEUE_PTR_W:0] count_reg, count_next;
    logic [7:0] query_data_reg, query_data_next;
    logic query_valid_reg, query_valid_next;
    logic queue_pop, queue_push;
    logic [7:0] push_code;
    function automatic logic [QUEUE_PTR_W-1:0] ptr_inc(input logic [QUEUE_PTR_W-1:0] p);
        ptr_inc = (p == PTR_LAST) ? '0 : QUEUE_PTR_W'(p + 1'b1);
    endfunction
    always_comb begin
        std_set = '0;
        std_set[STD_OPC_BIT] = STD_OPC_EV;
        std_set[STD_QUERY_ERR_BIT] = STD_QUERY_ERR_EV;
        std_set[STD_DEV_ERR_BIT] = STD_DEV_ERR_EV;
        std_set[STD_EXEC_ERR_BIT] = STD_EXEC_ERR_EV;
        std_set[STD_CMD_ERR_BIT] = STD_CMD_ERR_EV;
        std_set[STD_PWR_ON_BIT] = STD_PWR_ON_EV;
    end
    assign ev_query_rd = EV_QUERY && !EV_SEL[2];
    always_comb begin
        std_ev_next = std_ev_reg;
        comm_ev_next = comm_ev_reg;
        instr_ev_next = instr_ev_reg;
        lock_ev_next = lock_ev_reg;
        if (ev_query_rd) begin
            case (sers_sel_type'(EV_SEL))
                SERS_SEL_STD_EVENTS: std_ev_next = REG_RESET;
                SERS_SEL_COMM_EVENTS: comm_ev_next = REG_RESET;
                SERS_SEL_INSTR_EVENTS: instr_ev_next = REG_RESET;
                SERS_SEL_LOCK_EVENTS: lock_ev_next = REG_RESET;
                default: ;
            endcase
        end
        if (CLEAR_STATUS) begin
            std_ev_next = REG_RESET;
            comm_ev_next = REG_RESET;
            instr_ev_next = REG_RESET;
            lock_ev_next = REG_RESET;
        end
        std_ev_next = std_ev_next | (std_set & STD_USED_MASK);
        comm_ev_next = comm_ev_next | COMM_ERROR_EV;
        instr_ev_next = instr_ev_next | INSTR_EV;
        lock_ev_next = lock_ev_next | LOCK_EV;
    end
    always_comb begin
        std_mask_next = std_mask_reg;
        comm_mask_next = comm_mask_reg;
        instr_mask_next = instr_mask_reg;
        lock_mask_next = lock_mask_reg;
        srq_mask_next = srq_mask_reg;
        pwr_clear_next = pwr_clear_reg;
        load_done_next = 1'b1;
        if (!load_done_reg) begin
            pwr_clear_next = NV_PWR_CLEAR;
            std_mask_next = NV_PWR_CLEAR ? REG_RESET : NV_STD_MASK;
            srq_mask_next = NV_PWR_CLEAR ? REG_RESET : NV_SRQ_MASK;
        end else begin
            if (MASK_WRITE) begin
                case (sers_sel_type'(EV_SEL))
                    SERS_SEL_STD_MASK: std_mask_next = MASK_WDATA;
                    SERS_SEL_COMM_MASK: comm_mask_next = MASK_WDATA;
                    SERS_SEL_INSTR_MASK: instr_mask_next = MASK_WDATA;
                    SERS_SEL_LOCK_MASK: lock_mask_next = MASK_WDATA;
                    default: ;
                endcase
            end
            if (AUX_WRITE) begin
                case (sers_asel_type'(AUX_SEL))
                    SERS_ASEL_SRQ_MASK: srq_mask_next = MASK_WDATA;
                    SERS_ASEL_PWR_CLEAR: pwr_clear_next = MASK_WDATA[0];
                    default: ;
                endcase
            end
        end
    end
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            std_ev_reg <= REG_RESET;
            comm_ev_reg <= REG_RESET;
            instr_ev_reg <= REG_RESET;
            lock_ev_reg <= REG_RESET;
            std_mask_reg <= REG_RESET;
            comm_mask_reg <= REG_RESET;
            instr_mask_reg <= REG_RESET;
            lock_mask_reg <= REG_RESET;
            srq_mask_reg <= REG_RESET;
            pwr_clear_reg <= 1'b0;
            load_done_reg <= 1'b0;
        end else begin
            std_ev_reg <= std_ev_next;
            comm_ev_reg <= comm_ev_next;
            instr_ev_reg <= instr_ev_next;
            lock_ev_reg <= lock_ev_next;
            std_mask_reg <= std_mask_next;
            comm_mask_reg <= comm_mask_next;
            instr_mask_reg <= instr_mask_next;
            lock_mask_reg <= lock_mask_next;
            srq_mask_reg <= srq_mask_next;
            pwr_clear_reg <= pwr_clear_next;
            load_done_reg <= load_done_next;
        end
    end
    // ****************************************
    // Status byte
    // ****************************************
    always_comb begin
        status_byte = '0;
        status_byte[POLL_INSTR_BIT] = any_masked(instr_ev_reg, instr_mask_reg);
        status_byte[POLL_LOCK_BIT] = any_masked(lock_ev_reg, lock_mask_reg);
        status_byte[POLL_COMM_BIT] = any_masked(comm_ev_reg, comm_mask_reg);
        status_byte[POLL_MAV_BIT] = OUT_BUF_NOT_EMPTY;
        status_byte[POLL_STD_BIT] = any_masked(std_ev_reg, std_mask_reg);
        status_byte[POLL_MSS_BIT] = any_masked(status_byte, srq_mask_reg);
    end
    // ****************************************
    // Error queue and query answers
    // ****************************************
    // Event query wins, so the queue must not lose an entry it never answered
    assign queue_pop = AUX_QUERY && !EV_QUERY && (count_reg != '0)
        && (sers_asel_type'(AUX_SEL) == SERS_ASEL_ERROR_QUEUE);
    assign queue_push = ERR_PUSH && (count_reg < COUNT_FULL || queue_pop);
    assign push_code = (count_reg - (queue_pop ? 1'b1 : 1'b0) >= COUNT_DROP) ? ERR_TOO_MANY : ERR_CODE;

    always_comb begin
        query_valid_next = EV_QUERY | AUX_QUERY;
        query_data_next = query_data_reg;
        if (EV_QUERY) begin
            case (sers_sel_type'(EV_SEL))
                SERS_SEL_STD_EVENTS: query_data_next = std_ev_reg;
                SERS_SEL_COMM_EVENTS: query_data_next = comm_ev_reg;
                SERS_SEL_INSTR_EVENTS: query_data_next = instr_ev_reg;
                SERS_SEL_LOCK_EVENTS: query_data_next = lock_ev_reg;
                SERS_SEL_STD_MASK: query_data_next = std_mask_reg;
                SERS_SEL_COMM_MASK: query_data_next = comm_mask_reg;
                SERS_SEL_INSTR_MASK: query_data_next = instr_mask_reg;
                default: query_data_next = lock_mask_reg;
            endcase
        end else if (AUX_QUERY) begin
            case (sers_asel_type'(AUX_SEL))
                SERS_ASEL_SRQ_MASK: query_data_next = srq_mask_reg;
                // status byte read is side-effect free
                SERS_ASEL_STATUS_BYTE: query_data_next = status_byte;
                SERS_ASEL_ERROR_QUEUE: query_data_next = (count_reg != '0) ? queue_mem[rd_ptr_reg] : ERR_NONE;
                default: query_data_next = {7'h00, pwr_clear_reg};
            endcase
        end
        rd_ptr_next = queue_pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
        wr_ptr_next = queue_push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
        count_next = count_reg + (queue_push ? 1'b1 : 1'b0) - (queue_pop ? 1'b1 : 1'b0);
        if (CLEAR_STATUS) begin
            rd_ptr_next = '0;
            wr_ptr_next = '0;
            count_next = '0;
        end
    end
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_ptr_reg <= '0;
            wr_ptr_reg <= '0;
            count_reg <= '0;
            query_data_reg <= REG_RESET;
            query_valid_reg <= 1'b0;
        end else begin
            rd_ptr_reg <= rd_ptr_next;
            wr_ptr_reg <= wr_ptr_next;
            count_reg <= count_next;
            query_data_reg <= query_data_next;
            query_valid_reg <= query_valid_next;
        end
    end
    // Storage has no reset; contents are guarded by the count
    always_ff @(posedge CLK) begin
        if (queue_push && !CLEAR_STATUS) begin
            queue_mem[wr_ptr_reg] <= push_code;
        end
    end
    assign QUERY_DATA = query_data_reg;
    assign QUERY_VALID = query_valid_reg;
    assign STATUS_BYTE = status_byte;
    assign SERVICE_REQUEST = status_byte[POLL_MSS_BIT];
    assign PWR_CLEAR_FLAG = pwr_clear_reg;
    assign SRQ_MASK_OUT = srq_mask_reg;
    assign STD_MASK_OUT = std_mask_reg;
endmodule

// ### common/sers_pkg.sv
// Purpose: Constants for the status event reporting unit
// Assumes: 8-bit status registers, one system clock
// Notes: Bit positions follow the serial poll status byte layout
package sers_pkg;
    localparam int REG_W = 8;
    localparam int QUEUE_DEPTH = 20;
    localparam int QUEUE_PTR_W = 5;
    // Status byte bit positions
    localparam int POLL_INSTR_BIT = 0;
    localparam int POLL_LOCK_BIT = 1;
    localparam int POLL_COMM_BIT = 2;
    localparam int POLL_MAV_BIT = 4;
    localparam int POLL_STD_BIT = 5;
    localparam int POLL_MSS_BIT = 6;
    // Standard event bit positions
    localparam int STD_OPC_BIT = 0;
    localparam int STD_QUERY_ERR_BIT = 2;
    localparam int STD_DEV_ERR_BIT = 3;
    localparam int STD_EXEC_ERR_BIT = 4;
    localparam int STD_CMD_ERR_BIT = 5;
    localparam int STD_PWR_ON_BIT = 7;
    localparam logic [7:0] STD_USED_MASK = 8'hbd;
    // Error codes
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_TOO_MANY = 8'hfe;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [QUEUE_PTR_W-1:0] PTR_LAST = 5'h13;
    localparam logic [QUEUE_PTR_W-1:0] COUNT_DROP = 5'h13;
    localparam logic [QUEUE_PTR_W:0] COUNT_FULL = 6'h14;
    // Register select codes for the query and set ports
    typedef enum logic [2:0] {
        SERS_SEL_STD_EVENTS,
        SERS_SEL_COMM_EVENTS,
        SERS_SEL_INSTR_EVENTS,
        SERS_SEL_LOCK_EVENTS,
        SERS_SEL_STD_MASK,
        SERS_SEL_COMM_MASK,
        SERS_SEL_INSTR_MASK,
        SERS_SEL_LOCK_MASK
    } sers_sel_type;
    typedef enum logic [1:0] {
        SERS_ASEL_SRQ_MASK,
        SERS_ASEL_STATUS_BYTE,
        SERS_ASEL_ERROR_QUEUE,
        SERS_ASEL_PWR_CLEAR
    } sers_asel_type;
endpackage

// ### testbench/sers_status_checker.sv
// Purpose: Port-level assertions for the status unit
// Assumes: One clock, reset active low
// Notes: The mask load edge after reset is excluded from the hold check
`timescale 1ns/1ns
module sers_status_checker
    import sers_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic EV_QUERY,
    input wire logic [2:0] EV_SEL,
    input wire logic MASK_WRITE,
    input wire logic [7:0] MASK_WDATA,
    input wire logic AUX_QUERY,
    input wire logic AUX_WRITE,
    input wire logic [1:0] AUX_SEL,
    input wire logic CLEAR_STATUS,
    input wire logic OUT_BUF_NOT_EMPTY,
    input wire logic [7:0] QUERY_DATA,
    input wire logic QUERY_VALID,
    input wire logic [7:0] STATUS_BYTE,
    input wire logic SERVICE_REQUEST,
    input wire logic [7:0] SRQ_MASK_OUT,
    input wire logic [7:0] STD_MASK_OUT
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    chk_reserved_zero: assert property (STATUS_BYTE[7] == 1'b0 && STATUS_BYTE[3] == 1'b0)
        else $error("Reserved status bit set");
    chk_srq_level: assert property (SERVICE_REQUEST == STATUS_BYTE[POLL_MSS_BIT])
        else $error("Service request differs from master bit");
    chk_mss_value: assert property (STATUS_BYTE[6] == |(STATUS_BYTE[5:0] & SRQ_MASK_OUT[5:0]))
        else $error("Master summary bit wrong");
    chk_buf_bit: assert property (STATUS_BYTE[POLL_MAV_BIT] == OUT_BUF_NOT_EMPTY)
        else $error("Buffer bit wrong");
    chk_query_pulse: assert property (QUERY_VALID == $past(EV_QUERY || AUX_QUERY))
        else $error("Answer strobe wrong");
    chk_status_read: assert property (AUX_QUERY && AUX_SEL == 2'h1 && !EV_QUERY |=> QUERY_DATA == $past(STATUS_BYTE))
        else $error("Status byte answer wrong");
    chk_std_summary: assert property (EV_QUERY && EV_SEL == 3'h0 |=>
        $past(STATUS_BYTE[5]) == |(QUERY_DATA & $past(STD_MASK_OUT)))
        else $error("Standard summary bit wrong");
    chk_mask_write: assert property (MASK_WRITE && EV_SEL == 3'h4 |=> STD_MASK_OUT == $past(MASK_WDATA))
        else $error("Standard mask not written");
    chk_mask_hold: assert property ($past(RST_N, 4) && $changed(SRQ_MASK_OUT) |->
        $past(AUX_WRITE && AUX_SEL == 2'h0))
        else $error("Request mask changed unasked");
    cover property (SERVICE_REQUEST);
    cover property (AUX_QUERY && AUX_SEL == 2'h2 && !EV_QUERY);
    cover property (CLEAR_STATUS);
endmodule
bind sers_status_unit sers_status_checker u_chk (.CLK, .RST_N, .EV_QUERY, .EV_SEL, .MASK_WRITE, .MASK_WDATA,
    .AUX_QUERY, .AUX_WRITE, .AUX_SEL, .CLEAR_STATUS, .OUT_BUF_NOT_EMPTY, .QUERY_DATA, .QUERY_VALID,
    .STATUS_BYTE, .SERVICE_REQUEST, .SRQ_MASK_OUT, .STD_MASK_OUT);

// ### testbench/sers_host.sv
// Purpose: Remote host model issuing status commands
// Assumes: One command at a time, each held for one edge
// Notes: Idle select and data show the inverse of the last value
`timescale 1ns/1ns
module sers_host (
    input wire logic clk,
    output logic [5:0] cmd,
    output logic [2:0] sel,
    output logic [7:0] data
);
    // ****************
    // Command strobes
    // ****************
    initial begin
        cmd = 6'h00;
        sel = 3'h0;
        data = 8'h00;
    end
    task automatic send(input logic [5:0] c, input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        #1 cmd = c;
        sel = s;
        data = d;
        @(posedge clk);
        #1 cmd = 6'h00;
        sel = ~s;
        data = ~d;
    endtask
endmodule

// ### testbench/test_status_event_reporting.sv
// Purpose: Self-checking bench for the status unit
// Assumes: Host model drives commands, bench drives events
// Notes: Answers are matched against a queue of notes
`timescale 1ns/1ns
module test_status_event_reporting
    import sers_pkg::*;
();
    // ****************
    // Stimulus and checks
    // ****************
    localparam logic [5:0] EQ = 6'h01, AQ = 6'h02, MW = 6'h04, AW = 6'h08, CL = 6'h10, EP = 6'h20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic buf_ne = 1'b0;
    logic nv_clr = 1'b0;
    logic [7:0] nv_srq = 8'h00;
    logic [7:0] nv_std = 8'h00;
    logic [7:0] evs [4] = '{default: 8'h00};
    logic [5:0] cmd;
    logic [2:0] sel;
    logic [7:0] data, qd, sb, srq_m, std_m, v, w, m, poll_exp;
    logic qv, srq, psc;
    logic [7:0] expq [$];
    logic [7:0] codes [25];
    int seed = 32'h00d9aaf1;
    int bad_count = 0;
    int checks = 0;
    int pos [4] = '{POLL_STD_BIT, POLL_COMM_BIT, POLL_INSTR_BIT, POLL_LOCK_BIT};
    always #5 clk = ~clk;
    sers_host host (.clk(clk), .cmd(cmd), .sel(sel), .data(data));
    sers_status_unit dut (.CLK(clk), .RST_N(rst_n), .STD_OPC_EV(evs[0][0]), .STD_QUERY_ERR_EV(evs[0][2]),
        .STD_DEV_ERR_EV(evs[0][3]), .STD_EXEC_ERR_EV(evs[0][4]), .STD_CMD_ERR_EV(evs[0][5]),
        .STD_PWR_ON_EV(evs[0][7]), .COMM_ERROR_EV(evs[1]), .INSTR_EV(evs[2]), .LOCK_EV(evs[3]),
        .OUT_BUF_NOT_EMPTY(buf_ne), .ERR_PUSH(cmd[5]), .ERR_CODE(data), .CLEAR_STATUS(cmd[4]),
        .EV_QUERY(cmd[0]), .EV_SEL(sel), .MASK_WRITE(cmd[2]), .MASK_WDATA(data), .AUX_QUERY(cmd[1]),
        .AUX_WRITE(cmd[3]), .AUX_SEL(sel[1:0]), .NV_PWR_CLEAR(nv_clr), .NV_SRQ_MASK(nv_srq),
        .NV_STD_MASK(nv_std), .QUERY_DATA(qd), .QUERY_VALID(qv), .STATUS_BYTE(sb), .SERVICE_REQUEST(srq),
        .PWR_CLEAR_FLAG(psc), .SRQ_MASK_OUT(srq_m), .STD_MASK_OUT(std_m));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    always @(negedge clk) begin
        if (qv === 1'b1) begin
            if (expq.size() > 0) begin
                chk("query answer", expq.pop_front(), qd);
            end else begin
                bad_count++;
                $display("Error query answer expected none seen %h", qd);
            end
        end
    end
    task automatic q(input logic [5:0] c, input logic [2:0] s, input logic [7:0] e);
        expq.push_back(e);
        host.send(c, s, 8'h00);
    endtask
    task automatic ev(input int i, input logic [7:0] x);
        @(posedge clk);
        #1 evs[i] = x;
        @(posedge clk);
        #1 evs[i] = 8'h00;
    endtask
    task automatic rst(input logic f);
        @(posedge clk);
        #1 rst_n = 1'b0;
        nv_clr = f;
        nv_srq = 8'($random(seed));
        nv_std = 8'($random(seed));
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("power clear flag", {7'h00, f}, {7'h00, psc});
        chk("request mask", f ? 8'h00 : nv_srq, srq_m);
        chk("standard mask", f ? 8'h00 : nv_std, std_m);
    endtask
    task automatic report_and_stop();
        $display("Counts: %0d compared, %0d wrong", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        rst(1'b1);
        rst(1'b0);
        $display("Test power-on masks done");
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            w = 8'($random(seed));
            m = 8'($random(seed));
            host.send(MW, 3'(4 + i), m);
            ev(i, v);
            ev(i, w);
            v = (i == 0) ? ((v | w) & STD_USED_MASK) : (v | w);
            chk("summary bit", {7'h00, |(v & m)}, {7'h00, sb[pos[i]]});
            q(EQ, 3'(4 + i), m);
            q(EQ, 3'(i), v);
            q(EQ, 3'(i), 8'h00);
            q(EQ, 3'(4 + i), m);
            chk("summary cleared", 8'h00, {7'h00, sb[pos[i]]});
        end
        $display("Test event registers done");
        buf_ne = 1'($random(seed));
        m = 8'($random(seed)) | 8'h88;
        host.send(AW, 3'h0, m);
        for (int i = 0; i < 4; i++) begin
            host.send(MW, 3'(4 + i), 8'hff);
            ev(i, 8'hff);
        end
        poll_exp = {3'h1, buf_ne, 4'h7};
        poll_exp[6] = |(poll_exp & m & 8'h3f);
        chk("service request", {7'h00, poll_exp[6]}, {7'h00, srq});
        q(AQ, 3'h1, poll_exp);
        q(AQ, 3'h1, poll_exp);
        q(AQ, 3'h0, m);
        chk("status byte", poll_exp, sb);
        host.send(AW, 3'h0, 8'h88);
        chk("reserved request", 8'h00, {7'h00, srq});
        host.send(AW, 3'h3, 8'h01);
        q(AQ, 3'h3, 8'h01);
        chk("power clear written", 8'h01, {7'h00, psc});
        $display("Test status byte done");
        host.send(EP, 3'h0, 8'h0a);
        host.send(CL, 3'h0, 8'h00);
        for (int i = 0; i < 4; i++) q(EQ, 3'(i), 8'h00);
        q(AQ, 3'h2, ERR_NONE);
        chk("status after clear", {3'h0, buf_ne, 4'h0}, sb);
        $display("Test clear status done");
        for (int k = 0; k < 25; k++) begin
            codes[k] = 8'($random(seed));
            host.send(EP, 3'h0, codes[k]);
        end
        for (int k = 0; k < 21; k++) q(AQ, 3'h2, k < 19 ? codes[k] : (k == 19 ? ERR_TOO_MANY : ERR_NONE));
        $display("Test error queue done");
        for (int k = 0; k < 20 && expq.size() > 0; k++) @(posedge clk);
        if (expq.size() > 0) chk("pending answers", 8'h00, 8'(expq.size()));
        report_and_stop();
    end
endmodule
